/* File: hdl/ebm_out_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_out_stage (
    input wire logic clk_i,
    input wire logic rst_i,
    ebm_port_if.stage p
);
    import ebm_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } stage_state_t;

    stage_state_t st_r;
    stage_state_t st_nxt;
    logic clr_now;

    // Asynchronous style clears the output combinationally at once
    assign clr_now = p.global_rst | (p.async_rst & p.local_rst);

    always_comb begin
        st_nxt = st_r;
        if (p.global_rst || p.local_rst) begin
            st_nxt.data = DATA_RST;
        end else if (p.out_reg_en) begin
            st_nxt.data = p.rd_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        if (clr_now) begin
            p.out_data = DATA_RST;
        end else if (p.out_reg_en) begin
            p.out_data = st_r.data;
        end else begin
            p.out_data = p.rd_data;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/ebm_pkg.sv */
package ebm_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 36;
    localparam int DEPTH = 512;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

    typedef enum logic [1:0] {
        WR_NORMAL = 2'b00,
        WR_THROUGH = 2'b01,
        WR_READ_FIRST = 2'b11
    } write_mode_t;

    // Widths at which read-before-write may be selected
    localparam int W_X9 = 9;
    localparam int W_X18 = 18;
    localparam int W_X36 = 36;
endpackage

/* File: hdl/ebm_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ebm_port_if;
    import ebm_pkg::*;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] out_data;
    logic local_rst;
    logic async_rst;
    logic global_rst;
    logic out_reg_en;
    modport core (output rd_data, output local_rst, output async_rst,
                  output global_rst, output out_reg_en, input out_data);
    modport stage (input rd_data, input local_rst, input async_rst,
                   input global_rst, input out_reg_en, output out_data);
endinterface
`default_nettype wire

/* File: hdl/embedded_block_memory.sv */
// What this block does
// - Address and write data of each port are registered before the array.
// - Each port may add an output register or present read data direct.
// - Normal mode: output changes on reads and resets only, never shows written data.
// - Write-through mode: output shows the data written this cycle.
// - Read-before-write shows old content; only at 9, 18, 36 bit widths.
// - Write modes apply in single-port and in dual-port operation.
// - Each port has its own local reset clearing only its output latch.
// - Each output reset is set to act synchronously or asynchronously.
// - Global reset clears both ports' output latches together.
// - Read data reaches the outputs one edge after the capture edge, two with the output register.
`timescale 1ns/1ps
`default_nettype none
module embedded_block_memory #(
    parameter ebm_pkg::write_mode_t MODE_A = ebm_pkg::WR_NORMAL,
    parameter ebm_pkg::write_mode_t MODE_B = ebm_pkg::WR_NORMAL,
    parameter int WIDTH_A = ebm_pkg::DATA_W,
    parameter int WIDTH_B = ebm_pkg::DATA_W,
    parameter bit OUT_REG_A = 1'b0,
    parameter bit OUT_REG_B = 1'b0,
    parameter bit ASYNC_RST_A = 1'b0,
    parameter bit ASYNC_RST_B = 1'b0,
    parameter bit DUAL_PORT = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Port A
    input wire logic [ebm_pkg::ADDR_W-1:0] port_a_addr_i,
    input wire logic [ebm_pkg::DATA_W-1:0] port_a_wdata_i,
    input wire logic port_a_en_i,
    input wire logic port_a_we_i,
    input wire logic port_a_output_reset_i,
    output logic [ebm_pkg::DATA_W-1:0] port_a_rdata_o,
    // Port B
    input wire logic [ebm_pkg::ADDR_W-1:0] port_b_addr_i,
    input wire logic [ebm_pkg::DATA_W-1:0] port_b_wdata_i,
    input wire logic port_b_en_i,
    input wire logic port_b_we_i,
    input wire logic port_b_output_reset_i,
    output logic [ebm_pkg::DATA_W-1:0] port_b_rdata_o,
    // Device-wide reset
    input wire logic global_set_reset_n_i
);
    import ebm_pkg::*;

    localparam int NP = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic en;
        logic we;
        logic [DATA_W-1:0] latch;
        logic [DATA_W-1:0] outq;
    } port_state_t;

    typedef struct packed {
        port_state_t [NP-1:0] prt;
    } ebm_state_t;

    ebm_state_t st_r;
    ebm_state_t st_nxt;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] rd_raw [NP];
    logic [ADDR_W-1:0] addr_in [NP];
    logic [DATA_W-1:0] wdata_in [NP];
    logic en_in [NP];
    logic we_in [NP];
    logic lrst_in [NP];
    logic [DATA_W-1:0] stage_out [NP];
    logic clr_in [NP];

    assign addr_in[0] = port_a_addr_i;
    assign wdata_in[0] = port_a_wdata_i;
    assign en_in[0] = port_a_en_i;
    assign we_in[0] = port_a_we_i;
    assign lrst_in[0] = port_a_output_reset_i;
    // Single-port use leaves port B idle; the modes still apply to A
    assign addr_in[1] = port_b_addr_i;
    assign wdata_in[1] = port_b_wdata_i;
    assign en_in[1] = port_b_en_i & DUAL_PORT;
    assign we_in[1] = port_b_we_i;
    assign lrst_in[1] = port_b_output_reset_i;

    function automatic write_mode_t legal_mode(write_mode_t m, int w);
        bit width_ok;
        // Read-before-write is not offered at other widths
        case (w)
            W_X9, W_X18, W_X36: width_ok = 1'b1;
            default: width_ok = 1'b0;
        endcase
        if (m == WR_READ_FIRST && !width_ok) begin
            return WR_NORMAL;
        end
        return m;
    endfunction

    localparam write_mode_t EFF_A = legal_mode(MODE_A, WIDTH_A);
    localparam write_mode_t EFF_B = legal_mode(MODE_B, WIDTH_B);

    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < NP; i++) begin
            st_nxt.prt[i].addr = addr_in[i];
            st_nxt.prt[i].wdata = wdata_in[i];
            st_nxt.prt[i].en = en_in[i];
            st_nxt.prt[i].we = we_in[i];
            if (clr_in[i]) begin
                // Cleared here as well, so the port stays clear once the
                // reset drops, with or without its output register
                st_nxt.prt[i].latch = DATA_RST;
            end else begin
                st_nxt.prt[i].latch = rd_raw[i];
            end
            st_nxt.prt[i].outq = stage_out[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Array written from the captured registers; port B wins a collision
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NP; i++) begin
            if (st_r.prt[i].en && st_r.prt[i].we) begin
                mem[st_r.prt[i].addr] <= st_r.prt[i].wdata;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_port
            localparam write_mode_t EM = (g == 0) ? EFF_A : EFF_B;
            localparam bit OREG = (g == 0) ? OUT_REG_A : OUT_REG_B;
            localparam bit ARST = (g == 0) ? ASYNC_RST_A : ASYNC_RST_B;
            port_state_t ps;
            logic rd_go;
            logic wr_go;
            ebm_port_if pif ();
            assign ps = st_r.prt[g];
            assign rd_go = ps.en & ~ps.we;
            assign wr_go = ps.en & ps.we;
            assign clr_in[g] = lrst_in[g] | ~global_set_reset_n_i;

            // The array takes a write one edge after capture, so
            // read-before-write still sees the old word all cycle long
            always_comb begin
                rd_raw[g] = ps.latch;
                if (rd_go) begin
                    rd_raw[g] = mem[ps.addr];
                end else if (wr_go) begin
                    unique case (EM)
                        WR_NORMAL: rd_raw[g] = ps.latch;
                        WR_THROUGH: rd_raw[g] = ps.wdata;
                        WR_READ_FIRST: rd_raw[g] = mem[ps.addr];
                        default: rd_raw[g] = ps.latch;
                    endcase
                end
            end

            assign pif.rd_data = rd_raw[g];
            assign pif.local_rst = lrst_in[g];
            assign pif.async_rst = ARST;
            assign pif.global_rst = ~global_set_reset_n_i;
            assign pif.out_reg_en = OREG;
            assign stage_out[g] = pif.out_data;

            ebm_out_stage u_stage (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .p(pif)
            );
        end
    endgenerate

    // Outputs are the flopped copy of the output stage (one extra cycle)
    assign port_a_rdata_o = st_r.prt[0].outq;
    assign port_b_rdata_o = st_r.prt[1].outq;
endmodule
`default_nettype wire

/* File: tb/ebm_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_asserts import ebm_pkg::*; (
    input wire logic clk_i, rst_i, global_set_reset_n_i,
    input wire logic port_a_en_i, port_a_we_i, port_a_output_reset_i,
    input wire logic port_b_en_i, port_b_we_i, port_b_output_reset_i,
    input wire logic [DATA_W-1:0] port_a_wdata_i,
    input wire logic [DATA_W-1:0] port_a_rdata_o, port_b_rdata_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire qa = !port_a_output_reset_i && global_set_reset_n_i;
    wire qb = !port_b_output_reset_i && global_set_reset_n_i;
    wire act_a = port_a_en_i || !qa;
    wire act_b = port_b_en_i && !port_b_we_i || !qb;
    sequence s_wr_a; port_a_en_i && port_a_we_i && qa ##1 qa; endsequence
    sequence s_wr_b; port_b_en_i && port_b_we_i && qb ##1 qb; endsequence
    property p_through_a;
        s_wr_a |-> ##1 port_a_rdata_o == $past(port_a_wdata_i, 2);
    endproperty
    property p_hold_b; s_wr_b |-> ##1 $stable(port_b_rdata_o); endproperty
    property p_rst_a; port_a_output_reset_i |-> ##2 port_a_rdata_o == '0;
    endproperty
    property p_rst_b; port_b_output_reset_i |-> ##2 port_b_rdata_o == '0;
    endproperty
    property p_iso_a;
        (port_b_output_reset_i && !port_a_en_i && qa) ##1 qa
            |-> ##1 $stable(port_a_rdata_o);
    endproperty
    property p_global;
        !global_set_reset_n_i ##1 !global_set_reset_n_i
            |-> ##1 port_a_rdata_o == '0 && port_b_rdata_o == '0;
    endproperty
    // Output may move two edges after its cause, or one edge after a global reset
    // Port A clears asynchronously, one edge sooner than its reads
    property p_chg_a;
        $changed(port_a_rdata_o) |-> $past(act_a, 2)
            || !$past(global_set_reset_n_i)
            || $past(port_a_output_reset_i);
    endproperty
    property p_chg_b;
        $changed(port_b_rdata_o) |-> $past(act_b, 2)
            || !$past(global_set_reset_n_i);
    endproperty
    a_through_a: assert property (p_through_a)
        else $error("write data not shown on port a");
    a_hold_b: assert property (p_hold_b)
        else $error("port b output moved on a write");
    a_rst_a: assert property (p_rst_a)
        else $error("port a output not cleared");
    a_rst_b: assert property (p_rst_b)
        else $error("port b output not cleared");
    a_iso_a: assert property (p_iso_a)
        else $error("port b reset disturbed port a");
    a_global: assert property (p_global)
        else $error("global reset left an output set");
    a_chg_a: assert property (p_chg_a)
        else $error("port a output moved without cause");
    a_chg_b: assert property (p_chg_b)
        else $error("port b output moved without a read");
endmodule
`default_nettype wire

/* File: tb/ebm_fabric.sv */
`timescale 1ns/1ps
`default_nettype none
module ebm_fabric import ebm_pkg::*; (
    output logic [ADDR_W-1:0] port_a_addr_i, port_b_addr_i,
    output logic [DATA_W-1:0] port_a_wdata_i, port_b_wdata_i,
    output logic port_a_en_i, port_a_we_i, port_b_en_i, port_b_we_i
);
    // Mode, output register and reset style are never touched here
    task automatic drive(input logic [1:0] en, we,
        input logic [ADDR_W-1:0] aa, ab, input logic [DATA_W-1:0] da, db);
        {port_b_en_i, port_a_en_i} = en;
        {port_b_we_i, port_a_we_i} = we;
        {port_a_addr_i, port_b_addr_i} = {aa, ab};
        {port_a_wdata_i, port_b_wdata_i} = {da, db};
    endtask
endmodule
`default_nettype wire

/* File: tb/embedded_block_memory_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module embedded_block_memory_bench;
    import ebm_pkg::*;
    typedef struct {int due; bit b; logic [DATA_W-1:0] v;} note_t;
    // Capture edge, then the output flop
    localparam int LAT = 2;
    localparam bit ASYNC_A = 1'b1;
    logic clk_i = 0, rst_i = 1, global_set_reset_n_i = 1;
    logic port_a_output_reset_i = 0, port_b_output_reset_i = 0;
    logic [ADDR_W-1:0] port_a_addr_i, port_b_addr_i;
    logic [DATA_W-1:0] port_a_wdata_i, port_b_wdata_i, got, la = 0, lb = 0;
    logic port_a_en_i, port_a_we_i, port_b_en_i, port_b_we_i;
    logic [DATA_W-1:0] port_a_rdata_o, port_b_rdata_o, mem [DEPTH];
    note_t q[$];
    note_t n;
    int cyc, n_mismatch, checked;
    always #5 clk_i = ~clk_i;
    ebm_fabric i_fab (.*);
    embedded_block_memory #(.MODE_A(WR_THROUGH), .ASYNC_RST_A(ASYNC_A))
        i_dut (.*);
    function automatic logic [DATA_W-1:0] rnd();
        return DATA_W'({$urandom, $urandom});
    endfunction
    task automatic note(input bit b, input logic [DATA_W-1:0] v);
        q.push_back('{cyc + LAT, b, v});
    endtask
    // Every cycle notes both ports, so held values are checked as well
    task automatic step(input logic [1:0] en, we,
        input logic [ADDR_W-1:0] aa, ab, input logic [DATA_W-1:0] da, db,
        input logic [2:0] rs = 0);
        @(negedge clk_i);
        i_fab.drive(en, we, aa, ab, da, db);
        {global_set_reset_n_i, port_b_output_reset_i,
            port_a_output_reset_i} = rs ^ 3'b100;
        // An asynchronous clear already empties the result due next edge
        foreach (q[i]) begin
            if (q[i].due == cyc + 1 &&
                    (rs[2] || (ASYNC_A && rs[0] && !q[i].b)))
                q[i].v = '0;
        end
        if (rs[0] || rs[2]) la = '0;
        if (rs[1] || rs[2]) lb = '0;
        if (en[0]) la = we[0] ? da : mem[aa];
        if (en[1] && !we[1]) lb = mem[ab];
        note(0, la);
        note(1, lb);
        if (en[0] && we[0]) mem[aa] = da;
        if (en[1] && we[1]) mem[ab] = db;
    endtask
    // Enables low with live noise elsewhere: nothing may be taken
    task automatic idle(input logic [2:0] rs);
        step(0, 3, ADDR_W'($urandom), ADDR_W'($urandom), rnd(), rnd(), rs);
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        #1;
        cyc++;
        while (q.size() > 0 && q[0].due == cyc) begin
            n = q.pop_front();
            got = n.b ? port_b_rdata_o : port_a_rdata_o;
            checked++;
            if (got !== n.v) begin
                n_mismatch++;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, n.v);
            end
        end
    end
    initial begin
        void'($urandom(32'h1f63));
        i_fab.drive(0, 0, 0, 0, 0, 0);
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) rst_i = 0;
        for (int i = 0; i < 16; i++)
            step(3, 3, ADDR_W'(i), ADDR_W'(i + 16), rnd(), rnd());
        $display("test fill done");
        for (int i = 0; i < 200; i++)
            step(2'($urandom), 2'($urandom), ADDR_W'($urandom % 16),
                ADDR_W'(16 + $urandom % 16), rnd(), rnd());
        $display("test random done");
        idle(3'b001);
        idle(0);
        idle(3'b010);
        idle(0);
        $display("test local reset done");
        for (int i = 0; i < 16; i++)
            step(3, 0, ADDR_W'(i + 16), ADDR_W'(i), rnd(), rnd());
        $display("test cross read done");
        idle(3'b100);
        idle(3'b100);
        repeat (3) idle(0);
        $display("test global reset done");
        wait (q.size() == 0);
        results();
    end
    initial begin
        #50000;
        n_mismatch++;
        results();
    end
endmodule
bind embedded_block_memory ebm_asserts i_chk (.*);
`default_nettype wire
